// ---- bench/vpic_core_model.sv ----
/* vpic_core_model: processor core taking vectors and returning.
 * assumes: same hclk as vpic_top; bench steers it by ack_en and ret_go. */
`timescale 1ns/10ps
module vpic_core_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       ack_en,
  input  wire logic [3:0] ack_dly,
  input  wire logic       ret_go,
  input  wire logic       core_req,
  input  wire logic [3:0] cpu_level,
  output logic            core_ack,
  output logic            core_return,
  output logic      [3:0] restore_level
);
  logic [3:0] wait_q;
  logic [3:0] saved_q;
  //////////////////////////////////////////////////////////////////////
  // take ack_dly+1 cycles after core_req, keep level of the interrupted code
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_ack <= 1'b0;
      wait_q   <= 4'h0;
      saved_q  <= 4'h0;
    end else if (core_ack) begin
      core_ack <= 1'b0;
      wait_q   <= 4'h0;
      if (core_req) saved_q <= cpu_level;
    end else if (core_req && ack_en) begin
      if (wait_q == ack_dly) core_ack <= 1'b1;
      else wait_q <= wait_q + 4'h1;
    end
  end
  // end of service, only on bench command
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_return   <= 1'b0;
      restore_level <= 4'h0;
    end else begin
      core_return   <= ret_go;
      restore_level <= saved_q;
    end
  end
endmodule : vpic_core_model

// ---- bench/vpic_monitor.sv ----
/* vpic_monitor: port assertions on the core side of vpic_top.
 * assumes: one hclk domain; bound to vpic_top at the foot of this file. */
`timescale 1ns/10ps
module vpic_monitor (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        core_ack,
  input wire logic        core_return,
  input wire logic [3:0]  restore_level,
  input wire logic        core_req,
  input wire logic        core_req_trap,
  input wire logic [6:0]  core_vector,
  input wire logic [23:0] core_vec_addr,
  input wire logic [3:0]  cpu_level
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire usr = core_req && !core_req_trap;
  //////////////////////////////////////////////////////////////////////
  vec_addr_a: assert property (core_req |->
    core_vec_addr[7:0] == 8'h04 + {core_vector, 1'b0} && core_vec_addr[23:9] == 15'h0)
    else $error("table address does not match vector");
  trap_vec_a: assert property (core_req_trap |-> core_req && core_vector < 7'h08)
    else $error("trap vector out of range");
  user_vec_a: assert property (usr |-> core_vector inside {[7'h08:7'h4F]})
    else $error("user vector out of range");
  user_gate_a: assert property (usr |-> cpu_level < 4'h7)
    else $error("user vector above blocking level");
  trap_ack_a: assert property (core_req_trap && core_ack |=>
    !core_req ##1 cpu_level[3])
    else $error("trap take did not raise level");
  user_ack_a: assert property (usr && core_ack |=>
    !core_req ##1 (!cpu_level[3] && cpu_level > $past(cpu_level)))
    else $error("user take level wrong");
  trap_hold_a: assert property (core_req_trap && !core_ack |=> core_req_trap)
    else $error("trap presentation lost");
  ret_level_a: assert property (core_return && !(core_ack && core_req) |=>
    ##1 cpu_level == $past(restore_level, 2)) else $error("return level not restored");
  top_rise_a: assert property ($rose(cpu_level[3]) |->
    $past(core_ack, 2) && $past(core_req_trap, 2) || $past(core_return, 2))
    else $error("top level bit rose without trap");
  trap_take_c: cover property (core_req_trap && core_ack);
  user_take_c: cover property (usr && core_ack);
  ret_c: cover property (core_return);
endmodule : vpic_monitor
bind vpic_top vpic_monitor mon (.hclk, .hresetn, .core_ack, .core_return, .restore_level,
  .core_req, .core_req_trap, .core_vector, .core_vec_addr, .cpu_level);

// ---- bench/vpic_tb_top.sv ----
/* vpic_tb_top: self-checking bench of vpic_top over AHB-Lite.
 * assumes: vpic_pkg compiled first; core model in vpic_core_model. */
`timescale 1ns/10ps
module vectored_priority_interrupt_controller_tb_top;
  import vpic_pkg::*;
  typedef struct packed {
    logic [6:0] n;
    logic [2:0] p;
    logic       alt;
    logic [6:0] v;
    logic [23:0] a;
  } vpic_row_t;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [NSRC-1:0] src_event = '0;
  logic [NTRAP-1:0] trap_event = '0;
  logic [NEXT-1:0] ext_pin = '0;
  logic core_ack, core_return, core_req, core_req_trap, irq;
  logic ack_en = 1'b0, ret_go = 1'b0;
  logic [3:0] restore_level, cpu_level;
  logic [6:0] core_vector;
  logic [23:0] core_vec_addr;
  int fail_count = 0, comparisons = 0, n;
  vpic_row_t r;
  vpic_row_t rows [6] = '{'{7'h00, 3'h1, 1'b0, 7'h08, 24'h000014},
    '{7'h2E, 3'h3, 1'b0, 7'h36, 24'h000070}, '{7'h30, 3'h7, 1'b1, 7'h38, 24'h000174},
    '{7'h41, 3'h2, 1'b0, 7'h49, 24'h000096}, '{7'h45, 3'h5, 1'b1, 7'h4D, 24'h00019E},
    '{7'h47, 3'h4, 1'b0, 7'h4F, 24'h0000A2}};
  logic [7:0] regs [6] = '{OFS_GC1, OFS_GC2, OFS_VSTAT, OFS_CPUST, OFS_CORE, 8'hFC};
  //////////////////////////////////////////////////////////////////////
  vpic_top uut (.hclk, .hresetn, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .src_event,
    .ext_pin, .trap_event, .div0_event(1'b0), .core_ack, .core_return,
    .restore_level, .core_req, .core_req_trap, .core_vector, .core_vec_addr,
    .cpu_level, .irq);
  vpic_core_model core (.hclk, .hresetn, .ack_en, .ack_dly(4'h1), .ret_go, .core_req,
    .cpu_level, .core_ack, .core_return, .restore_level);
  initial begin
    forever #25 hclk = ~hclk;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic test_done;
    if (fail_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 20);
    if (hreadyout !== 1'b1) begin
      chk(hreadyout, 1'b1);
      test_done();
    end
  endtask : wait_rdy
  task automatic bus(input logic [7:0] a, input logic w, input logic [15:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0, d};
    wait_rdy();
    rd = hrdata;
  endtask : bus
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 16'h0);
    chk(rd, e);
    chk(hresp, 1'b0);
  endtask : rchk
  task automatic fire(input logic [6:0] s);
    @(posedge hclk);
    src_event[s] <= 1'b1;
    @(posedge hclk);
    src_event[s] <= 1'b0;
  endtask : fire
  task automatic settle(input logic req);
    for (n = 0; n < 20 && core_req !== req; n++) @(negedge hclk);
    if (core_req !== req) begin
      chk(core_req, req);
      test_done();
    end
    repeat (3) @(negedge hclk);
  endtask : settle
  task automatic reset_chk;
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (regs[i]) rchk(regs[i], 32'h0);
  endtask : reset_chk
  //////////////////////////////////////////////////////////////////////
  initial begin
    reset_chk();
    foreach (rows[i]) begin
      r = rows[i];
      bus(OFS_GC2, 1'b1, {r.alt, 15'h0});
      bus(OFS_PRI0 + 8'(r.n / 4 * 4), 1'b1, 16'(r.p) << (r.n % 4 * 4));
      bus(OFS_EN0 + 8'(r.n / 16 * 4), 1'b1, 16'h1 << (r.n % 16));
      fire(r.n);
      settle(1'b1);
      chk(core_vector, r.v);
      chk(core_vec_addr, r.a);
      rchk(OFS_VSTAT, 32'({1'b0, r.p, 1'b0, r.v}));
      rchk(OFS_FLAG0 + 8'(r.n / 16 * 4), 32'(16'h1 << (r.n % 16)));
      bus(OFS_FLAG0 + 8'(r.n / 16 * 4), 1'b1, 16'h0);
      bus(OFS_EN0 + 8'(r.n / 16 * 4), 1'b1, 16'h0);
      settle(1'b0);
      chk(core_req, 1'b0);
    end
    bus(OFS_GC2, 1'b1, 16'h0);
    bus(OFS_EN0 + 8'h10, 1'b1, 16'hFFFF);
    bus(OFS_PRI0 + 8'h40, 1'b1, 16'h7000);
    fire(7'h43);
    fire(7'h03);
    settle(1'b0);
    chk(core_req, 1'b0);
    rchk(OFS_FLAG0 + 8'h10, 32'h0);
    rchk(OFS_FLAG0, 32'h8);
    @(posedge hclk);
    ext_pin <= 5'h02;
    repeat (4) @(posedge hclk);
    ext_pin <= 5'h00;
    rchk(OFS_FLAG0 + 8'h04, 32'h10);
    bus(OFS_FLAG0, 1'b1, 16'h0);
    bus(OFS_EN0 + 8'h10, 1'b1, 16'h0);
    bus(OFS_PRI0 + 8'h04, 1'b1, 16'h0030);
    bus(OFS_PRI0 + 8'h08, 1'b1, 16'h0300);
    bus(OFS_PRI0 + 8'h14, 1'b1, 16'h0006);
    bus(OFS_EN0, 1'b1, 16'h0420);
    bus(OFS_EN0 + 8'h04, 1'b1, 16'h0010);
    fire(7'h0A);
    fire(7'h14);
    fire(7'h05);
    settle(1'b1);
    chk(core_vector, 32'h1C);
    bus(OFS_EN0 + 8'h04, 1'b1, 16'h0);
    settle(1'b1);
    chk(core_vector, 32'h0D);
    bus(OFS_CPUST, 1'b1, 16'h0060);
    settle(1'b0);
    chk(core_req, 1'b0);
    rchk(OFS_CPUST, 32'h60);
    bus(OFS_PRI0 + 8'h04, 1'b1, 16'h0070);
    bus(OFS_CPUST, 1'b1, 16'h00E0);
    settle(1'b0);
    chk(core_req, 1'b0);
    bus(OFS_GC1, 1'b1, 16'h8000);
    bus(OFS_CPUST, 1'b1, 16'h0000);
    rchk(OFS_CPUST, 32'hE0);
    rchk(OFS_GC1, 32'h8000);
    bus(OFS_GC1, 1'b1, 16'h0);
    bus(OFS_CPUST, 1'b1, 16'h0);
    bus(OFS_CORE, 1'b1, 16'h0008);
    rchk(OFS_CORE, 32'h0);
    settle(1'b1);
    bus(OFS_GC2, 1'b1, 16'h8000);
    @(posedge hclk);
    trap_event <= 8'h04;
    @(posedge hclk);
    trap_event <= 8'h00;
    repeat (3) @(negedge hclk);
    chk({core_req_trap, core_vector, core_vec_addr}, {1'b1, 7'h02, 24'h000108});
    rchk(OFS_GC1, 32'h8);
    rchk(OFS_VSTAT, 32'hF02);
    @(posedge hclk);
    ack_en <= 1'b1;
    settle(1'b0);
    chk(cpu_level, 32'h8);
    rchk(OFS_CORE, 32'h8);
    @(posedge hclk);
    ret_go <= 1'b1;
    @(posedge hclk);
    ret_go <= 1'b0;
    for (n = 0; n < 20 && cpu_level !== 4'h7; n++) @(negedge hclk);
    chk(cpu_level, 32'h7);
    if (cpu_level !== 4'h7) test_done();
    @(posedge hclk);
    ack_en <= 1'b0;
    bus(OFS_CPUST, 1'b1, 16'h0);
    bus(OFS_GC1, 1'b1, 16'h8000);
    settle(1'b0);
    chk(core_req, 1'b0);
    bus(OFS_GC1, 1'b1, 16'h0);
    settle(1'b1);
    chk(core_vector, 32'h0D);
    rchk(OFS_EVST, 32'h3);
    bus(OFS_EVMSK, 1'b1, 16'h0002);
    repeat (2) @(negedge hclk);
    chk(irq, 1'b1);
    bus(OFS_EVMSK, 1'b1, 16'h0);
    repeat (2) @(negedge hclk);
    chk(irq, 1'b0);
    bus(OFS_EVMSK, 1'b1, 16'h0003);
    bus(OFS_EVST, 1'b1, 16'h0003);
    rchk(OFS_EVST, 32'h0);
    chk(irq, 1'b0);
    reset_chk();
    test_done();
  end
endmodule : vectored_priority_interrupt_controller_tb_top

// ---- design/vpic_top.sv ----
/*
 * vpic_top: vectored priority interrupt controller with AHB-Lite registers.
 * assumes: request and trap pulses and core handshakes come from logic on hclk;
 * external request pins are asynchronous and are synchronised here.
 */
`timescale 1ns/10ps

module vpic_top
  import vpic_pkg::*;
(
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              ce,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic [NSRC-1:0]   src_event,
  input  wire logic [NEXT-1:0]   ext_pin,
  input  wire logic [NTRAP-1:0]  trap_event,
  input  wire logic              div0_event,
  input  wire logic              core_ack,
  input  wire logic              core_return,
  input  wire logic [3:0]        restore_level,
  output logic                   core_req,
  output logic                   core_req_trap,
  output logic      [6:0]        core_vector,
  output logic      [23:0]       core_vec_addr,
  output logic      [3:0]        cpu_level,
  output logic                   irq
);

  ////////////////////////////////////////////////////////////////////////////
  // bus address phase capture

  logic              wr_q;
  logic [7:0]        waddr_q;
  logic              rd_take;
  logic [15:0]       rdata_d;
  logic [15:0]       wdat;

  assign rd_take = hsel & htrans[1] & hready;
  assign wdat    = hwdata[15:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q      <= 1'b0;
      waddr_q   <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (ce) begin
      wr_q      <= rd_take & hwrite;
      waddr_q   <= {haddr[7:2], 2'b00};
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (rd_take & !hwrite) begin
        hrdata <= {16'h0000, rdata_d};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  logic              nest_disable;
  logic              alt_table_select;
  logic [15:0]       gc1_trap_q;
  logic [NEXT-1:0]   ext_pol_q;
  logic [2:0]        lvl_lo_q;
  logic              priority_level_top_bit;
  logic [NEV-1:0]    ev_stat_q;
  logic [NEV-1:0]    ev_mask_q;
  logic [NEV-1:0]    ev_set;
  logic [15:0]       trap_flag_set;
  logic              in_service_q;
  logic              pres_trap_q;
  logic [2:0]        pres_pri_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nest_disable     <= 1'b0;
      alt_table_select <= 1'b0;
      ext_pol_q        <= '0;
      ev_mask_q        <= '0;
    end else if (ce && wr_q) begin
      if (waddr_q == OFS_GC1) begin
        nest_disable <= wdat[GC1_NEST];
      end
      if (waddr_q == OFS_GC2) begin
        alt_table_select <= wdat[GC2_ALT];
        ext_pol_q        <= wdat[NEXT-1:0];
      end
      if (waddr_q == OFS_EVMSK) begin
        ev_mask_q <= wdat[NEV-1:0];
      end
    end
  end

  // trap status flags: hardware set wins over a software clear
  always_comb begin
    trap_flag_set = 16'h0000;
    for (int t = 0; t < NTRAP; t++) begin
      if (trap_event[t] && TRAP_VALID[t]) begin
        trap_flag_set[TRAP_BIT[t]] = 1'b1;
      end
    end
    trap_flag_set[GC1_DIV0] = div0_event;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gc1_trap_q <= 16'h0000;
    end else if (ce) begin
      if (wr_q && waddr_q == OFS_GC1) begin
        gc1_trap_q <= ((wdat & GC1_TRAP_MASK) | trap_flag_set) & GC1_TRAP_MASK;
      end else begin
        gc1_trap_q <= (gc1_trap_q | trap_flag_set) & GC1_TRAP_MASK;
      end
    end
  end

  // processor level: software, core acknowledge and core return
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lvl_lo_q               <= 3'b000;
      priority_level_top_bit <= 1'b0;
      in_service_q           <= 1'b0;
    end else if (ce) begin
      if (core_ack && core_req) begin
        if (pres_trap_q) begin
          priority_level_top_bit <= 1'b1;
        end else begin
          lvl_lo_q     <= pres_pri_q;
          in_service_q <= 1'b1;
        end
      end else if (core_return) begin
        lvl_lo_q               <= restore_level[2:0];
        priority_level_top_bit <= restore_level[3];
        in_service_q           <= 1'b0;
      end else if (wr_q) begin
        if (waddr_q == OFS_CPUST && !nest_disable) begin
          lvl_lo_q <= wdat[CPU_LVL_LO+2:CPU_LVL_LO];
        end
        if (waddr_q == OFS_CORE && !wdat[CORE_TOP]) begin
          priority_level_top_bit <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // external pins: two-stage sync, then edge detect with polarity

  logic [NEXT-1:0]   ext_s1_q;
  logic [NEXT-1:0]   ext_s2_q;
  logic [NEXT-1:0]   ext_s3_q;
  logic [NEXT-1:0]   ext_edge;
  logic [NFLAG-1:0]  flag_set;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_s1_q <= '0;
      ext_s2_q <= '0;
      ext_s3_q <= '0;
    end else if (ce) begin
      ext_s1_q <= ext_pin;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  assign ext_edge = (ext_pol_q & ext_s3_q & ~ext_s2_q) | (~ext_pol_q & ext_s2_q & ~ext_s3_q);

  always_comb begin
    flag_set = {{(NFLAG-NSRC){1'b0}}, src_event};
    for (int e = 0; e < NEXT; e++) begin
      flag_set[EXT_IRQ[e]] = flag_set[EXT_IRQ[e]] | ext_edge[e];
    end
    flag_set = flag_set & ~RSV_MASK2;
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-source flag, enable and priority storage

  logic [NFLAG-1:0]  request_flag_regs;
  logic [NFLAG-1:0]  enable_bits;
  logic [2:0]        priority_regs [NSRC];
  logic [NSRC-1:0]   eligible;
  logic [3:0]        lvl;

  assign lvl = {priority_level_top_bit, lvl_lo_q};

  for (genvar i = 0; i < NFLAG; i++) begin : g_src
    localparam logic [7:0] FOFS = OFS_FLAG0 + 8'((i / 16) * 4);
    localparam logic [7:0] EOFS = OFS_EN0 + 8'((i / 16) * 4);
    if (RSV_MASK2[i]) begin : g_rsv
      assign request_flag_regs[i] = 1'b0;
      assign enable_bits[i]       = 1'b0;
    end else begin : g_live
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          request_flag_regs[i] <= 1'b0;
          enable_bits[i]       <= 1'b0;
        end else if (ce) begin
          if (flag_set[i]) begin
            request_flag_regs[i] <= 1'b1;
          end else if (wr_q && waddr_q == FOFS) begin
            request_flag_regs[i] <= wdat[i % 16];
          end
          if (wr_q && waddr_q == EOFS) begin
            enable_bits[i] <= wdat[i % 16];
          end
        end
      end
    end
    if (i < NSRC) begin : g_pri
      localparam logic [7:0] POFS = OFS_PRI0 + 8'((i / 4) * 4);
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          priority_regs[i] <= 3'b000;
        end else if (ce && wr_q && waddr_q == POFS) begin
          priority_regs[i] <= wdat[(i % 4) * 4 +: 3];
        end
      end
      assign eligible[i] = request_flag_regs[i] & enable_bits[i] &
                           ({1'b0, priority_regs[i]} > lvl) &
                           !(nest_disable & in_service_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // arbitration and vector presentation

  logic [NTRAP-1:0]  trap_pend_q;
  logic              user_found;
  logic [6:0]        user_idx;
  logic [2:0]        user_pri;
  logic              trap_found;
  logic [6:0]        trap_idx;
  logic              win_found;
  logic [6:0]        win_vec;
  logic [3:0]        win_lvl;

  always_comb begin
    user_found = 1'b0;
    user_idx   = 7'h00;
    user_pri   = 3'b000;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (eligible[i] && (!user_found || priority_regs[i] >= user_pri)) begin
        user_found = 1'b1;
        user_idx   = 7'(i);
        user_pri   = priority_regs[i];
      end
    end
    trap_found = 1'b0;
    trap_idx   = 7'h00;
    for (int t = NTRAP - 1; t >= 0; t--) begin
      if (trap_pend_q[t]) begin
        trap_found = 1'b1;
        trap_idx   = 7'(t);
      end
    end
    win_found = trap_found | user_found;
    if (trap_found) begin
      win_vec = trap_idx;
      win_lvl = 4'hF;
    end else begin
      win_vec = user_idx + VEC_USER_OFS;
      win_lvl = {1'b0, user_pri};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trap_pend_q <= '0;
    end else if (ce) begin
      for (int t = 0; t < NTRAP; t++) begin
        if (trap_event[t] && TRAP_VALID[t]) begin
          trap_pend_q[t] <= 1'b1;
        end else if (core_ack && core_req && pres_trap_q && core_vector == 7'(t)) begin
          trap_pend_q[t] <= 1'b0;
        end
      end
    end
  end

  logic [6:0]        latched_vector_number;
  logic [3:0]        latched_new_level;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_req              <= 1'b0;
      core_req_trap         <= 1'b0;
      core_vector           <= 7'h00;
      core_vec_addr         <= 24'h000000;
      latched_vector_number <= 7'h00;
      latched_new_level     <= 4'h0;
      pres_trap_q           <= 1'b0;
      pres_pri_q            <= 3'b000;
    end else if (ce) begin
      core_req      <= win_found & !(core_ack & core_req);
      core_req_trap <= trap_found & !(core_ack & core_req);
      pres_trap_q   <= trap_found;
      if (win_found) begin
        core_vector           <= win_vec;
        latched_vector_number <= win_vec;
        latched_new_level     <= win_lvl;
        pres_pri_q            <= user_pri;
        core_vec_addr         <= PRI_TBL_BASE + {16'h0000, win_vec, 1'b0} +
                                 (alt_table_select ? ALT_TBL_OFS : 24'h000000);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_level <= 4'h0;
    end else if (ce) begin
      cpu_level <= lvl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // block event status and interrupt line

  assign ev_set[EV_PRESENT] = win_found & !core_req;
  assign ev_set[EV_TRAP]    = |trap_flag_set;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ev_stat_q <= '0;
      irq       <= 1'b0;
    end else if (ce) begin
      if (wr_q && waddr_q == OFS_EVST) begin
        ev_stat_q <= (ev_stat_q & ~wdat[NEV-1:0]) | ev_set;
      end else begin
        ev_stat_q <= ev_stat_q | ev_set;
      end
      irq <= |(ev_stat_q & ev_mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux for the thirty-three controller words and the extras

  always_comb begin
    rdata_d = 16'h0000;
    for (int k = 0; k < NFLAG / 16; k++) begin
      if (haddr[7:0] == OFS_FLAG0 + 8'(k * 4)) begin
        rdata_d = request_flag_regs[k * 16 +: 16];
      end
      if (haddr[7:0] == OFS_EN0 + 8'(k * 4)) begin
        rdata_d = enable_bits[k * 16 +: 16];
      end
    end
    for (int p = 0; p < NPRIW; p++) begin
      if (haddr[7:0] == OFS_PRI0 + 8'(p * 4)) begin
        for (int j = 0; j < 4; j++) begin
          rdata_d[j * 4 +: 3] = priority_regs[p * 4 + j];
        end
      end
    end
    case (haddr[7:0])
      OFS_GC1:   rdata_d = gc1_trap_q | (16'h0001 << GC1_NEST) * 16'(nest_disable);
      OFS_GC2:   rdata_d = {alt_table_select, 10'h000, ext_pol_q};
      OFS_VSTAT: rdata_d = {4'h0, latched_new_level, 1'b0, latched_vector_number};
      OFS_CPUST: rdata_d = {8'h00, lvl_lo_q, 5'h00};
      OFS_CORE:  rdata_d = {12'h000, priority_level_top_bit, 3'b000};
      OFS_EVST:  rdata_d = {14'h0000, ev_stat_q};
      OFS_EVMSK: rdata_d = {14'h0000, ev_mask_q};
      default:   rdata_d = rdata_d;
    endcase
  end

endmodule : vpic_top

// ---- include/vpic_pkg.sv ----
/*
 * vpic_pkg: constants of the vectored priority interrupt controller.
 * assumes: one core clock; registers reached over an AHB-Lite slave port.
 */
package vpic_pkg;
  localparam int NSRC  = 72;            // sources with priority fields
  localparam int NFLAG = 80;            // five 16-bit flag/enable words
  localparam int NPRIW = 18;            // priority words
  localparam int NEXT  = 5;             // external request pins
  localparam int NTRAP = 8;

  // byte offsets of the AHB-Lite register map
  localparam logic [7:0] OFS_GC1    = 8'h00;
  localparam logic [7:0] OFS_GC2    = 8'h04;
  localparam logic [7:0] OFS_FLAG0  = 8'h10;
  localparam logic [7:0] OFS_EN0    = 8'h30;
  localparam logic [7:0] OFS_PRI0   = 8'h50;
  localparam logic [7:0] OFS_VSTAT  = 8'hA0;
  localparam logic [7:0] OFS_CPUST  = 8'hA4;
  localparam logic [7:0] OFS_CORE   = 8'hA8;
  localparam logic [7:0] OFS_EVST   = 8'hB0;
  localparam logic [7:0] OFS_EVMSK  = 8'hB4;

  // field positions
  localparam int GC1_NEST   = 15;
  localparam int GC2_ALT    = 15;
  localparam int CPU_LVL_LO = 5;        // lower level bits 7:5
  localparam int CORE_TOP   = 3;
  localparam int VS_LVL_LO  = 8;        // latched level bits 11:8
  localparam logic [15:0] GC1_TRAP_MASK = 16'h007E;
  localparam logic [15:0] GC2_POL_MASK  = 16'h001F;
  localparam int GC1_DIV0   = 6;

  // vector numbering and table addresses
  localparam logic [6:0]  VEC_USER_OFS = 7'h08;
  localparam logic [23:0] PRI_TBL_BASE = 24'h000004;
  localparam logic [23:0] ALT_TBL_OFS  = 24'h000100;

  // reserved request numbers (15,18,45,57-60,62-64,67,72-79)
  localparam logic [NFLAG-1:0] RSV_MASK2 = 80'h0000_0000_0000_0000_0000 |
    (80'h1 << 15) | (80'h1 << 18) | (80'h1 << 45) | (80'hF << 57) |
    (80'h7 << 62) | (80'h1 << 67) | (80'hFF << 72);

  // request numbers of the external pins 0..4
  localparam logic [6:0] EXT_IRQ [NEXT] = '{7'd0, 7'd20, 7'd29, 7'd53, 7'd54};

  // trap numbers: 1 osc fail, 2 address, 3 stack, 4 math, 5 dma; 0,6,7 reserved
  localparam logic [NTRAP-1:0] TRAP_VALID = 8'h3E;
  // trap number -> status bit in global control one
  localparam int TRAP_BIT [NTRAP] = '{0, 1, 3, 2, 4, 5, 0, 0};

  // own event status bits
  localparam int EV_PRESENT = 0;
  localparam int EV_TRAP    = 1;
  localparam int NEV        = 2;
endpackage : vpic_pkg
